// >>> rtl/trs_pkg.sv
package trs_pkg;
    localparam int TRS_NUM_INPUTS = 14;
    localparam int TRS_IDX_W = 4;
    localparam logic [TRS_IDX_W-1:0] TRS_NO_REF = 4'hf;
    localparam int TRS_PRIO_W = 4;
    localparam logic [TRS_PRIO_W-1:0] TRS_PRIO_OFF = 4'h0;
    localparam int TRS_CLK_HZ = 40000000;
    localparam int TRS_FRAME_HZ = 8000;
    // activity window: inputs must show a rising edge within this many cycles
    localparam int TRS_ACT_WINDOW = 256;
    localparam int TRS_ACT_W = 9;
    // frequency check: edges counted over one 8kHz period
    localparam int TRS_FRAME_CYCLES = TRS_CLK_HZ / TRS_FRAME_HZ;
    localparam int TRS_FRAME_W = 13;
    localparam int TRS_EDGE_W = 16;
    localparam int TRS_DIV_W = 16;
    localparam int TRS_FREQ_W = 24;
    localparam int TRS_HOLD_SHIFT = 8;
    localparam int TRS_WDT_CYCLES = 64;
    localparam int TRS_WDT_W = 7;
    localparam logic [TRS_IDX_W-1:0] TRS_COMPOSITE_A = 4'h0;
    localparam logic [TRS_IDX_W-1:0] TRS_COMPOSITE_B = 4'h1;

    typedef enum logic [2:0] {
        TRS_FREE_RUN = 3'b001,
        TRS_LOCKED = 3'b010,
        TRS_HOLDOVER = 3'b100
    } trs_state_type;
endpackage : trs_pkg

// >>> rtl/trs_input_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// one input: 3-flop sync, activity watch and 8kHz edge count window
module trs_input_monitor (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic ref_pin_in,
    input wire logic frame_tick_in,
    input wire logic [trs_pkg::TRS_EDGE_W-1:0] edges_min_in,
    input wire logic [trs_pkg::TRS_EDGE_W-1:0] edges_max_in,
    output logic edge_out,
    output logic valid_out
);
    logic s1_q, s2_q, s3_q, last_q;
    logic [trs_pkg::TRS_ACT_W-1:0] idle_q;
    logic [trs_pkg::TRS_EDGE_W-1:0] edges_q;
    logic freq_ok_q;
    wire logic agree_w = (s2_q == s3_q);
    wire logic rise_w = agree_w && s3_q && !last_q;
    wire logic active_w = (idle_q < trs_pkg::TRS_ACT_WINDOW[trs_pkg::TRS_ACT_W-1:0]);
    wire logic in_range_w = (edges_q >= edges_min_in) && (edges_q <= edges_max_in);

    assign edge_out = rise_w;
    assign valid_out = active_w && freq_ok_q;

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            last_q <= 1'b0;
            idle_q <= trs_pkg::TRS_ACT_WINDOW[trs_pkg::TRS_ACT_W-1:0];
            edges_q <= '0;
            freq_ok_q <= 1'b0;
        end
        else if (clk_en_in)
        begin
            s1_q <= ref_pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (agree_w)
                last_q <= s3_q;
            if (rise_w)
                idle_q <= '0;
            else if (active_w)
                idle_q <= idle_q + 1'b1;
            if (frame_tick_in)
            begin
                freq_ok_q <= in_range_w;
                edges_q <= '0;
            end
            else if (rise_w && edges_q != '1)
                edges_q <= edges_q + 1'b1;
        end
    end
endmodule : trs_input_monitor
`default_nettype wire

// >>> rtl/trs_selector.sv
`timescale 1ns/1ps
`default_nettype none
module trs_selector (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic [trs_pkg::TRS_NUM_INPUTS-1:0] ref_pins_in,
    input wire logic composite_input_a_in,
    input wire logic composite_input_b_in,
    input wire logic composite_enable_in,
    input wire logic [trs_pkg::TRS_NUM_INPUTS*trs_pkg::TRS_PRIO_W-1:0] main_prio_in,
    input wire logic [trs_pkg::TRS_NUM_INPUTS*trs_pkg::TRS_PRIO_W-1:0] aux_prio_in,
    input wire logic [trs_pkg::TRS_NUM_INPUTS*trs_pkg::TRS_DIV_W-1:0] divider_in,
    input wire logic [trs_pkg::TRS_EDGE_W-1:0] edges_min_in,
    input wire logic [trs_pkg::TRS_EDGE_W-1:0] edges_max_in,
    input wire logic revertive_in,
    input wire logic aux_follow_main_in,
    input wire logic aux_measure_in,
    input wire logic aux_measure_phase_in,
    input wire logic [trs_pkg::TRS_IDX_W-1:0] measure_a_in,
    input wire logic [trs_pkg::TRS_IDX_W-1:0] measure_b_in,
    input wire logic [trs_pkg::TRS_FREQ_W-1:0] local_freq_in,
    input wire logic [trs_pkg::TRS_FREQ_W-1:0] main_track_freq_in,
    input wire logic local_osc_clock_in,
    output logic [trs_pkg::TRS_NUM_INPUTS-1:0] valid_out,
    output logic [trs_pkg::TRS_IDX_W-1:0] main_ref_out,
    output logic [trs_pkg::TRS_IDX_W-1:0] aux_ref_out,
    output logic main_tick_out,
    output logic aux_tick_out,
    output logic [2:0] main_state_out,
    output logic [trs_pkg::TRS_FREQ_W-1:0] main_freq_out,
    output logic [trs_pkg::TRS_FREQ_W-1:0] holdover_freq_out,
    output logic [trs_pkg::TRS_FREQ_W-1:0] measure_out,
    output logic osc_fail_out
);
    localparam int N = trs_pkg::TRS_NUM_INPUTS;
    localparam int PW = trs_pkg::TRS_PRIO_W;
    localparam int IW = trs_pkg::TRS_IDX_W;
    localparam int FW = trs_pkg::TRS_FREQ_W;

    logic [N-1:0] pin_w, edge_w, valid_w;
    logic [trs_pkg::TRS_FRAME_W-1:0] frame_q;
    wire logic frame_tick_w = (frame_q == '0);
    // composite receivers take the place of the first two inputs when enabled
    assign pin_w[0] = composite_enable_in ? composite_input_a_in : ref_pins_in[0];
    assign pin_w[1] = composite_enable_in ? composite_input_b_in : ref_pins_in[1];
    assign pin_w[N-1:2] = ref_pins_in[N-1:2];

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            frame_q <= trs_pkg::TRS_FRAME_W'(trs_pkg::TRS_FRAME_CYCLES - 1);
        else if (clk_en_in)
            frame_q <= frame_tick_w ? trs_pkg::TRS_FRAME_W'(trs_pkg::TRS_FRAME_CYCLES - 1) : frame_q - 1'b1;
    end

    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_mon
            trs_input_monitor u_mon (
                .sys_clk_in(sys_clk_in),
                .rst_in(rst_in),
                .clk_en_in(clk_en_in),
                .ref_pin_in(pin_w[g]),
                .frame_tick_in(frame_tick_w),
                .edges_min_in(edges_min_in),
                .edges_max_in(edges_max_in),
                .edge_out(edge_w[g]),
                .valid_out(valid_w[g])
            );
        end
    endgenerate

    // best valid input per table; priority 1 is highest, 0 disables the entry
    function automatic logic [IW-1:0] best_ref(input logic [N*PW-1:0] table_in, input logic [N-1:0] ok);
        logic [IW-1:0] idx;
        logic [PW-1:0] best;
        logic [PW-1:0] p;
        idx = trs_pkg::TRS_NO_REF;
        best = '1;
        p = '0;
        for (int i = 0; i < N; i++)
        begin
            p = table_in[i*PW +: PW];
            if (ok[i] && p != trs_pkg::TRS_PRIO_OFF && (idx == trs_pkg::TRS_NO_REF || p < best))
            begin
                idx = IW'(i);
                best = p;
            end
        end
        return idx;
    endfunction : best_ref

    wire logic [IW-1:0] main_best_w = best_ref(main_prio_in, valid_w);
    wire logic [IW-1:0] aux_best_w = best_ref(aux_prio_in, valid_w);
    logic [IW-1:0] main_ref_q, aux_ref_q;
    wire logic main_cur_ok_w = (main_ref_q != trs_pkg::TRS_NO_REF) && valid_w[main_ref_q];
    // nonrevertive keeps a still-valid reference even if a better one returns
    wire logic main_take_w = revertive_in || !main_cur_ok_w;
    wire logic [IW-1:0] main_next_w = main_take_w ? main_best_w : main_ref_q;

    trs_pkg::trs_state_type state_q, state_d;
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            trs_pkg::TRS_FREE_RUN:
                if (main_next_w != trs_pkg::TRS_NO_REF)
                    state_d = trs_pkg::TRS_LOCKED;
            trs_pkg::TRS_LOCKED:
                if (!main_cur_ok_w)
                    state_d = trs_pkg::TRS_HOLDOVER;
            trs_pkg::TRS_HOLDOVER:
                if (main_next_w != trs_pkg::TRS_NO_REF)
                    state_d = trs_pkg::TRS_LOCKED;
        endcase
    end

    // per-input 8kHz dividers, one tick every programmed count plus one edges
    logic [N-1:0] div_tick_w;
    generate
        for (g = 0; g < N; g++)
        begin : g_div
            logic [trs_pkg::TRS_DIV_W-1:0] cnt_q;
            wire logic [trs_pkg::TRS_DIV_W-1:0] lim_w = divider_in[g*trs_pkg::TRS_DIV_W +: trs_pkg::TRS_DIV_W];
            wire logic wrap_w = cnt_q >= lim_w;
            assign div_tick_w[g] = edge_w[g] && wrap_w;
            always_ff @(posedge sys_clk_in)
            begin
                if (rst_in)
                    cnt_q <= '0;
                else if (clk_en_in && edge_w[g])
                    cnt_q <= wrap_w ? '0 :
                        cnt_q + 1'b1;
            end
        end
    endgenerate

    // aux may follow the main loop; its ticks then come from the main reference
    wire logic [IW-1:0] aux_next_w = aux_follow_main_in ? main_next_w : aux_best_w;
    wire logic main_tick_w = (main_ref_q != trs_pkg::TRS_NO_REF) && div_tick_w[main_ref_q];
    wire logic aux_tick_w = (aux_ref_q != trs_pkg::TRS_NO_REF) && div_tick_w[aux_ref_q];

    // frequency word: local in free-run, tracked when locked, stored in holdover
    logic [FW-1:0] freq_q, hold_q;
    wire logic [FW-1:0] freq_d = (state_q == trs_pkg::TRS_LOCKED) ? main_track_freq_in :
        (state_q == trs_pkg::TRS_HOLDOVER) ? hold_q : local_freq_in;
    // leaky average: slow enough to ride out wander, short glitches barely move it
    wire logic signed [FW+1:0] avg_step_w = ($signed({2'b00, main_track_freq_in}) -
        $signed({2'b00, hold_q})) >>> trs_pkg::TRS_HOLD_SHIFT;

    // measurement: edge count per frame, or cycles between edges of two inputs
    logic [FW-1:0] meas_cnt_q, meas_q;
    logic phase_run_q;
    wire logic edge_a_w = edge_w[measure_a_in];
    wire logic edge_b_w = edge_w[measure_b_in];

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            meas_cnt_q <= '0;
            meas_q <= '0;
            phase_run_q <= 1'b0;
        end
        else if (clk_en_in && aux_measure_in)
        begin
            if (!aux_measure_phase_in)
            begin
                if (frame_tick_w)
                begin
                    meas_q <= meas_cnt_q;
                    meas_cnt_q <= '0;
                end
                else if (edge_a_w)
                    meas_cnt_q <= meas_cnt_q + 1'b1;
            end
            else if (edge_a_w)
            begin
                phase_run_q <= 1'b1;
                meas_cnt_q <= '0;
            end
            else if (phase_run_q && edge_b_w)
            begin
                phase_run_q <= 1'b0;
                meas_q <= meas_cnt_q;
            end
            else if (phase_run_q)
                meas_cnt_q <= meas_cnt_q + 1'b1;
        end
    end

    // oscillator watchdog: osc pin must toggle within the window
    logic o1_q, o2_q, o3_q, olast_q;
    logic [trs_pkg::TRS_WDT_W-1:0] wdt_q;
    wire logic osc_agree_w = (o2_q == o3_q);
    wire logic osc_change_w = osc_agree_w && (o3_q != olast_q);
    wire logic wdt_exp_w = (wdt_q >= trs_pkg::TRS_WDT_CYCLES[trs_pkg::TRS_WDT_W-1:0]);

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            o1_q <= 1'b0;
            o2_q <= 1'b0;
            o3_q <= 1'b0;
            olast_q <= 1'b0;
            wdt_q <= '0;
            osc_fail_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            o1_q <= local_osc_clock_in;
            o2_q <= o1_q;
            o3_q <= o2_q;
            if (osc_agree_w)
                olast_q <= o3_q;
            if (osc_change_w)
                wdt_q <= '0;
            else if (!wdt_exp_w)
                wdt_q <= wdt_q + 1'b1;
            osc_fail_out <= wdt_exp_w && !osc_change_w;
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            state_q <= trs_pkg::TRS_FREE_RUN;
            main_ref_q <= trs_pkg::TRS_NO_REF;
            aux_ref_q <= trs_pkg::TRS_NO_REF;
            freq_q <= '0;
            hold_q <= '0;
            main_tick_out <= 1'b0;
            aux_tick_out <= 1'b0;
            valid_out <= '0;
        end
        else if (clk_en_in)
        begin
            state_q <= state_d;
            main_ref_q <= main_next_w;
            aux_ref_q <= aux_next_w;
            freq_q <= freq_d;
            if (state_q == trs_pkg::TRS_LOCKED)
                hold_q <= FW'($signed({2'b00, hold_q}) + avg_step_w);
            else if (state_q == trs_pkg::TRS_FREE_RUN)
                hold_q <= local_freq_in;
            main_tick_out <= main_tick_w;
            aux_tick_out <= aux_tick_w;
            valid_out <= valid_w;
        end
    end

    assign main_ref_out = main_ref_q;
    assign aux_ref_out = aux_ref_q;
    assign main_state_out = state_q;
    assign main_freq_out = freq_q;
    assign holdover_freq_out = hold_q;
    assign measure_out = meas_q;

    property hold_on_loss_p;
        @(posedge sys_clk_in) disable iff (rst_in)
        (clk_en_in && state_q == trs_pkg::TRS_LOCKED && !main_cur_ok_w) |=> (state_q == trs_pkg::TRS_HOLDOVER);
    endproperty
    hold_on_loss_a: assert property (hold_on_loss_p) else $error("no holdover after loss");
    reset_free_a: assert property (@(posedge sys_clk_in) rst_in |=>
        (state_q == trs_pkg::TRS_FREE_RUN && main_ref_q == trs_pkg::TRS_NO_REF))
        else $error("reset state wrong");
    sequence ref_ok_s;
        clk_en_in && state_q != trs_pkg::TRS_LOCKED && main_next_w != trs_pkg::TRS_NO_REF;
    endsequence
    lock_on_ref_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ref_ok_s |=> state_q == trs_pkg::TRS_LOCKED) else $error("did not lock");
    nonrev_keep_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (clk_en_in && !revertive_in && main_cur_ok_w) |=> $stable(main_ref_q))
        else $error("nonrevertive switched");
    rev_best_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (clk_en_in && revertive_in) |=> main_ref_q == $past(main_best_w))
        else $error("revertive not best");
    free_freq_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (clk_en_in && state_q == trs_pkg::TRS_FREE_RUN) |=> main_freq_out == $past(local_freq_in))
        else $error("free-run freq wrong");
    hold_freq_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (clk_en_in && state_q == trs_pkg::TRS_HOLDOVER) |=> main_freq_out == $past(hold_q))
        else $error("holdover freq wrong");
    sel_valid_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (state_q == trs_pkg::TRS_LOCKED && main_ref_q != trs_pkg::TRS_NO_REF) |-> valid_out[main_ref_q] ||
        $past(!valid_w[main_ref_q])) else $error("locked on invalid");
    wdt_flag_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        osc_fail_out |-> $past(wdt_exp_w)) else $error("spurious osc fail");
endmodule : trs_selector
`default_nettype wire

// >>> bench/trs_line_cards.sv
`timescale 1ns/1ps
`default_nettype none
// line card clocks (5MHz, or 10MHz when fast) and the local oscillator
// stopped pins sit low: the model drives them to 0
module trs_line_cards (
    input wire logic [15:0] run_in,
    input wire logic [15:0] fast_in,
    input wire logic osc_run_in,
    output logic [15:0] pins_out,
    output logic osc_out
);
    genvar g;
    generate
        for (g = 0; g < 16; g++)
        begin : g_src
            initial
            begin
                pins_out[g] = 1'b0;
                forever
                begin
                    if (run_in[g])
                    begin
                        #(fast_in[g] ? 50 : 100) pins_out[g] = run_in[g] & ~pins_out[g];
                    end
                    else
                    begin
                        pins_out[g] = 1'b0;
                        @(run_in[g]);
                        // keep pin edges clear of the sampling clock edge
                        #6.25;
                    end
                end
            end
        end
    endgenerate

    initial
    begin
        osc_out = 1'b0;
        forever
        begin
            #39.0625;
            osc_out = osc_run_in & ~osc_out;
        end
    end
endmodule : trs_line_cards
`default_nettype wire

// >>> bench/trs_selector_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define TRS_CHECK(name, exp, got) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            errors++; \
            $display("[ERR] %s expected %h seen %h", name, exp, got); \
        end \
    end
module trs_selector_tb_top;
    logic sys_clk_in, rst_in, clk_en, comp_en, revert, follow, meas, meas_ph, osc_run, osc;
    logic [15:0] run, fast, pins;
    logic [55:0] mprio, aprio;
    logic [223:0] div;
    logic [15:0] emin, emax;
    logic [3:0] ma, mb;
    logic [23:0] lfreq, tfreq;
    logic [13:0] valid;
    logic [3:0] mref, aref;
    logic mtick, atick, ofail;
    logic [2:0] st;
    logic [23:0] mfreq, hfreq, mout;
    int errors = 0;
    int num_checks = 0;

    trs_line_cards i_trs_line_cards (.run_in(run), .fast_in(fast), .osc_run_in(osc_run),
        .pins_out(pins), .osc_out(osc));

    trs_selector i_trs_selector (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(clk_en),
        .ref_pins_in(pins[13:0]), .composite_input_a_in(pins[14]), .composite_input_b_in(pins[15]),
        .composite_enable_in(comp_en), .main_prio_in(mprio), .aux_prio_in(aprio), .divider_in(div),
        .edges_min_in(emin), .edges_max_in(emax), .revertive_in(revert), .aux_follow_main_in(follow),
        .aux_measure_in(meas), .aux_measure_phase_in(meas_ph), .measure_a_in(ma), .measure_b_in(mb),
        .local_freq_in(lfreq), .main_track_freq_in(tfreq), .local_osc_clock_in(osc),
        .valid_out(valid), .main_ref_out(mref), .aux_ref_out(aref), .main_tick_out(mtick),
        .aux_tick_out(atick), .main_state_out(st), .main_freq_out(mfreq),
        .holdover_freq_out(hfreq), .measure_out(mout), .osc_fail_out(ofail));

    initial
    begin
        sys_clk_in = 1'b0;
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end

    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    function automatic logic [3:0] probe(input int w);
        case (w)
            0: probe = mref;
            1: probe = {1'b0, st};
            2: probe = {3'h0, ofail};
            default: probe = {3'h0, valid[w-4]};
        endcase
    endfunction : probe

    // bounded wait on one of the watched outputs
    task automatic wait_for(input int w, input logic [3:0] v, input int limit);
        int n;
        n = 0;
        while (probe(w) !== v)
        begin
            @(posedge sys_clk_in);
            #1;
            n++;
            if (n > limit)
            begin
                errors++;
                $display("[ERR] wait %0d expected %h seen %h", w, v, probe(w));
                wrap_up();
            end
        end
    endtask : wait_for

    task automatic set_prio(input int i, input logic [3:0] m, input logic [3:0] a);
        mprio[i*4 +: 4] <= m;
        aprio[i*4 +: 4] <= a;
    endtask : set_prio

    task automatic t_reset;
        repeat (3) @(posedge sys_clk_in);
        #1;
        `TRS_CHECK("state", trs_pkg::TRS_FREE_RUN, st)
        `TRS_CHECK("main_ref", trs_pkg::TRS_NO_REF, mref)
        `TRS_CHECK("aux_ref", trs_pkg::TRS_NO_REF, aref)
        `TRS_CHECK("valid", 14'h0, valid)
        `TRS_CHECK("free_freq", lfreq, mfreq)
    endtask : t_reset

    // 3 and 5 good, 7 off frequency, 9 good but disabled
    task automatic t_select;
        int cnt;
        @(posedge sys_clk_in);
        set_prio(3, 4'h2, 4'h1);
        set_prio(5, 4'h1, 4'h2);
        set_prio(7, 4'h1, 4'h1);
        div[5*16 +: 16] <= 16'h0018;
        run <= 16'h02a8;
        fast <= 16'h0080;
        wait_for(0, 4'h5, 12000);
        `TRS_CHECK("state", trs_pkg::TRS_LOCKED, st)
        `TRS_CHECK("aux_ref", 4'h3, aref)
        `TRS_CHECK("valid", 14'h0228, valid)
        cnt = 0;
        repeat (1000)
        begin
            @(posedge sys_clk_in);
            #1;
            cnt += (mtick === 1'b1);
        end
        `TRS_CHECK("tick_count", 1'b1, cnt >= 4 && cnt <= 6)
    endtask : t_select

    task automatic t_failover;
        repeat (8000) @(posedge sys_clk_in);
        #1;
        `TRS_CHECK("hold_avg", 12'h123, hfreq[23:12])
        @(posedge sys_clk_in);
        run[5] <= 1'b0;
        wait_for(9, 4'h0, 400);
        `TRS_CHECK("state", trs_pkg::TRS_HOLDOVER, st)
        `TRS_CHECK("main_ref", 4'h3, mref)
        @(posedge sys_clk_in);
        #1;
        `TRS_CHECK("state", trs_pkg::TRS_LOCKED, st)
    endtask : t_failover

    task automatic t_revert;
        @(posedge sys_clk_in);
        run[5] <= 1'b1;
        wait_for(0, 4'h5, 12000);
        @(posedge sys_clk_in);
        revert <= 1'b0;
        run[5] <= 1'b0;
        wait_for(0, 4'h3, 400);
        @(posedge sys_clk_in);
        run[5] <= 1'b1;
        wait_for(9, 4'h1, 12000);
        repeat (20) @(posedge sys_clk_in);
        #1;
        `TRS_CHECK("main_ref", 4'h3, mref)
    endtask : t_revert

    task automatic t_all_lost;
        @(posedge sys_clk_in);
        run <= 16'h0;
        wait_for(0, trs_pkg::TRS_NO_REF, 400);
        repeat (300) @(posedge sys_clk_in);
        #1;
        `TRS_CHECK("state", trs_pkg::TRS_HOLDOVER, st)
        `TRS_CHECK("hold_freq", hfreq, mfreq)
    endtask : t_all_lost

    // composite a replaces input 0; aux reaches it only by following main
    task automatic t_composite;
        @(posedge sys_clk_in);
        comp_en <= 1'b1;
        set_prio(0, 4'h1, 4'h0);
        run[14] <= 1'b1;
        wait_for(0, trs_pkg::TRS_COMPOSITE_A, 12000);
        @(posedge sys_clk_in);
        follow <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        #1;
        `TRS_CHECK("aux_follow", trs_pkg::TRS_COMPOSITE_A, aref)
        @(posedge sys_clk_in);
        follow <= 1'b0;
        meas <= 1'b1;
        repeat (11000) @(posedge sys_clk_in);
        #1;
        // a full 5000-cycle frame of a 5MHz input holds about 625 edges
        `TRS_CHECK("measure", 1'b1, mout >= 24'd620 && mout <= 24'd630)
        @(posedge sys_clk_in);
        meas_ph <= 1'b1;
        fast[15] <= 1'b1;
        run[15] <= 1'b1;
        repeat (100) @(posedge sys_clk_in);
        #1;
        // b rises every 4 cycles, so a to the next b stays under 4
        `TRS_CHECK("phase", 1'b1, mout < 24'd4)
    endtask : t_composite

    // frozen clock enable must hold the selection although the source died
    task automatic t_freeze_osc;
        @(posedge sys_clk_in);
        clk_en <= 1'b0;
        run[14] <= 1'b0;
        repeat (600) @(posedge sys_clk_in);
        #1;
        `TRS_CHECK("frozen_ref", trs_pkg::TRS_COMPOSITE_A, mref)
        `TRS_CHECK("osc_ok", 1'b0, ofail)
        @(posedge sys_clk_in);
        clk_en <= 1'b1;
        osc_run <= 1'b0;
        wait_for(2, 4'h1, 100);
    endtask : t_freeze_osc

    initial
    begin
        rst_in = 1'b1;
        clk_en = 1'b1;
        comp_en = 1'b0;
        revert = 1'b1;
        follow = 1'b0;
        meas = 1'b0;
        meas_ph = 1'b0;
        osc_run = 1'b1;
        run = 16'h0;
        fast = 16'h0;
        mprio = 56'h0;
        aprio = 56'h0;
        div = {14{16'h0270}};
        emin = 16'd600;
        emax = 16'd650;
        ma = 4'h0;
        mb = 4'h1;
        lfreq = 24'h0abcde;
        tfreq = 24'h123800;
        repeat (5) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_select();
        t_failover();
        t_revert();
        t_all_lost();
        t_composite();
        t_freeze_osc();
        wrap_up();
    end
endmodule : trs_selector_tb_top
`default_nettype wire
